// ---- hw/smp_pkg.sv ----
package smp_pkg;
	localparam int AW = 4;
	localparam int DW = 8;

	// Register offsets
	localparam logic [AW-1:0] OFS_CTRL = 4'h0;
	localparam logic [AW-1:0] OFS_STAT = 4'h1;
	localparam logic [AW-1:0] OFS_ACK  = 4'h2;

	// Control register fields
	localparam int CB_DBG_EN    = 0;
	localparam int CB_VM_EN     = 1;
	localparam int CB_VM_STOP   = 2;
	localparam int CB_DEEP_SEL  = 3;
	localparam int CB_STOP_EN   = 4;
	localparam int CB_VM_RST    = 5;
	localparam int CB_CONV_ACLK = 6;
	localparam logic [DW-1:0] CTRL_RST = 8'h00;
	localparam int AB_IO_REL    = 0;

	// Address regions
	localparam logic [15:0] DP_LO = 16'h0000;
	localparam logic [15:0] DP_HI = 16'h005f;
	localparam logic [15:0] HP_LO = 16'h1800;
	localparam logic [15:0] HP_HI = 16'h184f;
	localparam logic [15:0] NV_LO = 16'hffb0;
	localparam logic [15:0] NV_HI = 16'hffbf;
	localparam logic [15:0] UV_LO = 16'hffc0;
	localparam logic [15:0] UV_HI = 16'hffcf;

	typedef enum logic [3:0] {
		VEC_RESET, VEC_SWI, VEC_VMON, VEC_IRQ, VEC_T1C0, VEC_T1C1,
		VEC_T1OV, VEC_T2C0, VEC_T2OV, VEC_KEYPAD, VEC_CONV, VEC_WAKEUP
	} smp_vec_t;
	localparam int VEC_N = 12;
	// High-byte address of each vector, low byte follows at +1
	localparam logic [15:0] VEC_ADDR [VEC_N] = '{
		16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8, 16'hfff4, 16'hfff2,
		16'hfff0, 16'hffee, 16'hffea, 16'hffda, 16'hffd8, 16'hffd0
	};

	typedef enum logic [1:0] {MODE_RUN, MODE_LIGHT, MODE_DEEP, MODE_DEBUG} smp_mode_t;
	typedef enum logic [2:0] {
		CMD_MEM, CMD_MEM_STAT, CMD_BDREG, CMD_HALT, CMD_ACTIVE, CMD_GO
	} smp_cmd_t;

	typedef struct packed {
		logic     valid;
		smp_cmd_t cmd;
	} smp_dbg_req_t;

	typedef struct packed {
		logic ack;
		logic err;
		logic rej;
	} smp_dbg_rsp_t;

	typedef struct packed {
		logic periph_clk_en;
		logic dbg_clk_en;
		logic reg_full;
		logic conv_on;
		logic core_off;
		logic ram_standby;
		logic io_hold;
	} smp_pwr_t;

	typedef struct packed {
		logic dp;
		logic hp;
		logic nv;
		logic uvec;
	} smp_region_t;
endpackage : smp_pkg

// ---- hw/smp_ctrl.sv ----
`timescale 1ns/100ps
// Functional notes
// - Halt from run only when debug enabled
// - Debug clock kept in stop when enabled
// - Regulator full while debug enabled in stop
// - Deep request with debug enabled gives light
// - Stop rejects all but an enabled halt in light stop; status reads report error
// - Halt in light stop wakes to debug if enabled
// - Debug mode accepts every command class
// - Voltage trip raises interrupt or reset
// - Monitor enabled for stop keeps regulator
// - Deep request with monitor in stop gives light
// - Peripheral clocks stop in either stop
// - Peripheral clocks stop despite debug clock
// - Converter on in stop only with async clock, monitor
// - Decode direct, high, nonvolatile register regions
// - Vectors fetched two bytes, high first
// - Unused vector space flagged as user memory
// - Stop disabled forces illegal opcode reset
// - Select bit picks deep or light stop
module smp_ctrl (
	input  wire logic                 sys_clk_i,
	input  wire logic                 rst_i,
	input  wire logic [smp_pkg::AW-1:0] reg_addr_i,
	input  wire logic [smp_pkg::DW-1:0] reg_wdata_i,
	input  wire logic                 reg_wr_i,
	input  wire logic                 reg_rd_i,
	output logic      [smp_pkg::DW-1:0] reg_rdata_o,
	input  wire logic                 stop_exec_i,
	input  wire logic                 wake_i,
	input  wire smp_pkg::smp_dbg_req_t dbg_req_i,
	output smp_pkg::smp_dbg_rsp_t     dbg_rsp_o,
	input  wire logic                 lv_trip_i,
	output logic                      lv_irq_o,
	output logic                      lv_rst_o,
	output logic                      ilop_rst_o,
	output smp_pkg::smp_pwr_t         pwr_o,
	output smp_pkg::smp_mode_t        mode_o,
	input  wire logic [15:0]          cpu_addr_i,
	output smp_pkg::smp_region_t      region_o,
	input  wire logic                 vec_req_i,
	input  wire smp_pkg::smp_vec_t    vec_sel_i,
	output logic                      vec_rd_o,
	output logic      [15:0]          vec_addr_o,
	input  wire logic [7:0]           vec_data_i,
	output logic      [15:0]          vec_o,
	output logic                      vec_done_o
);
	import smp_pkg::*;

	logic [DW-1:0]  ctrl_ff;
	logic           io_hold_ff;
	logic           deep_woke_ff;
	logic           lv_meta_ff;
	logic           lv_sync_ff;
	logic           lv_prev_ff;
	smp_mode_t      mode_ff;
	smp_mode_t      nxt_mode;
	logic [1:0]     vf_step_ff;
	logic [15:0]    vf_base_ff;
	logic [7:0]     vf_hi_ff;

	wire dbg_en    = ctrl_ff[CB_DBG_EN];
	wire vm_en     = ctrl_ff[CB_VM_EN];
	wire vm_stop   = vm_en & ctrl_ff[CB_VM_STOP];
	wire deep_sel  = ctrl_ff[CB_DEEP_SEL];
	wire stop_en   = ctrl_ff[CB_STOP_EN];

	wire wr_ctrl   = reg_wr_i & (reg_addr_i == OFS_CTRL);
	wire wr_ack    = reg_wr_i & (reg_addr_i == OFS_ACK);
	wire io_rel    = wr_ack & reg_wdata_i[AB_IO_REL];

	// Stop request resolution
	wire in_run    = (mode_ff == MODE_RUN);
	wire in_stop   = (mode_ff == MODE_LIGHT) | (mode_ff == MODE_DEEP);
	wire in_dbg    = (mode_ff == MODE_DEBUG);
	wire stop_go   = in_run & stop_exec_i & stop_en;
	wire stop_bad  = in_run & stop_exec_i & ~stop_en;
	// Debug or monitor need full regulation, which deep stop cannot give
	wire deep_ok   = deep_sel & ~dbg_en & ~vm_stop;

	// Debug command classification
	wire cmd_v     = dbg_req_i.valid;
	wire cmd_halt  = cmd_v & (dbg_req_i.cmd == CMD_HALT);
	wire cmd_stat  = cmd_v & (dbg_req_i.cmd == CMD_MEM_STAT);
	wire cmd_act   = cmd_v & ((dbg_req_i.cmd == CMD_ACTIVE) | (dbg_req_i.cmd == CMD_GO));
	wire cmd_go    = cmd_v & (dbg_req_i.cmd == CMD_GO);
	// Deep stop has no debug clock, so a halt there is refused
	wire halt_ok   = cmd_halt & dbg_en & (in_run | (mode_ff == MODE_LIGHT));
	wire run_ok    = in_run & cmd_v & ~cmd_act & ~cmd_halt;
	wire nxt_ack   = halt_ok | run_ok | (in_dbg & cmd_v);
	wire nxt_err   = in_stop & cmd_stat;
	wire nxt_rej   = cmd_v & ~nxt_ack & ~nxt_err;

	always_comb begin
		nxt_mode = mode_ff;
		case (mode_ff)
			MODE_RUN: begin
				if (halt_ok)
					nxt_mode = MODE_DEBUG;
				else if (stop_go)
					nxt_mode = deep_ok ? MODE_DEEP : MODE_LIGHT;
			end
			MODE_LIGHT: begin
				if (halt_ok)
					nxt_mode = MODE_DEBUG;
				else if (wake_i)
					nxt_mode = MODE_RUN;
			end
			MODE_DEEP: begin
				if (wake_i)
					nxt_mode = MODE_RUN;
			end
			MODE_DEBUG: begin
				if (cmd_go)
					nxt_mode = MODE_RUN;
			end
			default: nxt_mode = MODE_RUN;
		endcase
	end

	// Power controls follow the next mode so they align with mode_o
	wire n_stop    = (nxt_mode == MODE_LIGHT) | (nxt_mode == MODE_DEEP);
	wire n_deep    = (nxt_mode == MODE_DEEP);
	wire n_io_hold = n_deep | (io_hold_ff & ~io_rel);
	smp_pwr_t nxt_pwr;
	assign nxt_pwr.periph_clk_en = ~n_stop;
	assign nxt_pwr.dbg_clk_en    = ~n_stop | dbg_en;
	assign nxt_pwr.reg_full      = ~n_stop | dbg_en | vm_stop;
	// Converter in light stop needs its own clock and the monitor
	assign nxt_pwr.conv_on       = ~n_stop |
		(~n_deep & ctrl_ff[CB_CONV_ACLK] & vm_en);
	assign nxt_pwr.core_off      = n_deep;
	assign nxt_pwr.ram_standby   = n_stop;
	assign nxt_pwr.io_hold       = n_io_hold;

	// Voltage monitor edge; deep stop turns the monitor off
	wire vm_live   = vm_en & (~in_stop | ctrl_ff[CB_VM_STOP]) & ~(mode_ff == MODE_DEEP);
	wire lv_rise   = lv_sync_ff & ~lv_prev_ff & vm_live;
	wire nxt_lv_rst = lv_rise & ctrl_ff[CB_VM_RST];
	wire nxt_lv_irq = lv_rise & ~ctrl_ff[CB_VM_RST];

	// Address decode
	smp_region_t nxt_region;
	assign nxt_region.dp   = (cpu_addr_i <= DP_HI);
	assign nxt_region.hp   = (cpu_addr_i >= HP_LO) & (cpu_addr_i <= HP_HI);
	assign nxt_region.nv   = (cpu_addr_i >= NV_LO) & (cpu_addr_i <= NV_HI);
	assign nxt_region.uvec = (cpu_addr_i >= UV_LO) & (cpu_addr_i <= UV_HI);

	// Register read mux
	logic [DW-1:0] rd_mux;
	assign rd_mux = (reg_addr_i == OFS_CTRL) ? ctrl_ff :
		(reg_addr_i == OFS_STAT) ?
			{3'h0, deep_woke_ff, lv_sync_ff, io_hold_ff, mode_ff} :
		8'h00;

	// Vector fetch: step 0 high byte address, step 1 low byte
	wire vf_idle   = (vf_step_ff == 2'd0);
	wire [15:0] vf_lo_addr = vf_base_ff + 16'h0001;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			ctrl_ff      <= CTRL_RST;
			mode_ff      <= MODE_RUN;
			io_hold_ff   <= 1'b0;
			deep_woke_ff <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_ff <= reg_wdata_i;
			mode_ff    <= nxt_mode;
			io_hold_ff <= n_io_hold;
			// Wake from deep wins over a same-cycle release
			if ((mode_ff == MODE_DEEP) & (nxt_mode == MODE_RUN))
				deep_woke_ff <= 1'b1;
			else if (io_rel)
				deep_woke_ff <= 1'b0;
		end
	end

	// Trip pin is asynchronous to the bus clock
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			lv_meta_ff <= 1'b0;
			lv_sync_ff <= 1'b0;
			lv_prev_ff <= 1'b0;
		end else begin
			lv_meta_ff <= lv_trip_i;
			lv_sync_ff <= lv_meta_ff;
			lv_prev_ff <= lv_sync_ff;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
			dbg_rsp_o   <= '0;
			lv_irq_o    <= 1'b0;
			lv_rst_o    <= 1'b0;
			ilop_rst_o  <= 1'b0;
			pwr_o       <= 7'b1110000;
			mode_o      <= MODE_RUN;
			region_o    <= '0;
		end else begin
			reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
			dbg_rsp_o   <= {nxt_ack, nxt_err, nxt_rej};
			lv_irq_o    <= nxt_lv_irq;
			lv_rst_o    <= nxt_lv_rst;
			ilop_rst_o  <= stop_bad;
			pwr_o       <= nxt_pwr;
			mode_o      <= nxt_mode;
			region_o    <= nxt_region;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			vf_step_ff <= 2'd0;
			vf_base_ff <= 16'h0000;
			vf_hi_ff   <= 8'h00;
			vec_rd_o   <= 1'b0;
			vec_addr_o <= 16'h0000;
			vec_o      <= 16'h0000;
			vec_done_o <= 1'b0;
		end else begin
			vec_done_o <= 1'b0;
			vec_rd_o   <= 1'b0;
			case (vf_step_ff)
				2'd0: begin
					if (vec_req_i) begin
						vf_base_ff <= VEC_ADDR[vec_sel_i];
						vec_addr_o <= VEC_ADDR[vec_sel_i];
						vec_rd_o   <= 1'b1;
						vf_step_ff <= 2'd1;
					end
				end
				2'd1: begin
					vec_addr_o <= vf_lo_addr;
					vec_rd_o   <= 1'b1;
					vf_step_ff <= 2'd2;
				end
				2'd2: begin
					vf_hi_ff   <= vec_data_i;
					vf_step_ff <= 2'd3;
				end
				2'd3: begin
					vec_o      <= {vf_hi_ff, vec_data_i};
					vec_done_o <= 1'b1;
					vf_step_ff <= 2'd0;
				end
				default: vf_step_ff <= 2'd0;
			endcase
		end
	end

	// Checks
	property p_halt_gate;
		@(posedge sys_clk_i) disable iff (rst_i)
		(in_run & cmd_halt & ~dbg_en) |=> (mode_o == MODE_RUN) & dbg_rsp_o.rej;
	endproperty
	a_halt_gate: assert property (p_halt_gate) else $error("halt taken while disabled");

	property p_dbg_clk;
		@(posedge sys_clk_i) disable iff (rst_i)
		(in_stop & dbg_en) |-> pwr_o.dbg_clk_en & pwr_o.reg_full;
	endproperty
	a_dbg_clk: assert property (p_dbg_clk) else $error("debug clock lost in stop");

	property p_no_deep_dbg;
		@(posedge sys_clk_i) disable iff (rst_i)
		(stop_go & (dbg_en | vm_stop)) |=> (mode_o == MODE_LIGHT);
	endproperty
	a_no_deep_dbg: assert property (p_no_deep_dbg) else $error("deep stop entered");

	property p_stat_err;
		@(posedge sys_clk_i) disable iff (rst_i)
		(in_stop & cmd_stat) |=> dbg_rsp_o.err & ~dbg_rsp_o.ack;
	endproperty
	a_stat_err: assert property (p_stat_err) else $error("status command not flagged");

	property p_halt_wake;
		@(posedge sys_clk_i) disable iff (rst_i)
		((mode_ff == MODE_LIGHT) & cmd_halt & dbg_en) |=> (mode_ff == MODE_DEBUG);
	endproperty
	a_halt_wake: assert property (p_halt_wake) else $error("halt did not wake");

	property p_dbg_all;
		@(posedge sys_clk_i) disable iff (rst_i)
		(in_dbg & cmd_v) |=> dbg_rsp_o.ack;
	endproperty
	a_dbg_all: assert property (p_dbg_all) else $error("command refused in debug");

	property p_lv_evt;
		@(posedge sys_clk_i) disable iff (rst_i)
		lv_rise |=> (lv_rst_o == $past(ctrl_ff[CB_VM_RST])) & (lv_irq_o != lv_rst_o);
	endproperty
	a_lv_evt: assert property (p_lv_evt) else $error("wrong monitor event");

	property p_periph_off;
		@(posedge sys_clk_i) disable iff (rst_i)
		(mode_o != MODE_RUN) & (mode_o != MODE_DEBUG) |-> ~pwr_o.periph_clk_en;
	endproperty
	a_periph_off: assert property (p_periph_off) else $error("peripheral clock running");

	property p_ilop;
		@(posedge sys_clk_i) disable iff (rst_i)
		(in_run & stop_exec_i & ~stop_en) |=> ilop_rst_o & (mode_o == MODE_RUN);
	endproperty
	a_ilop: assert property (p_ilop) else $error("stop not refused");

	property p_vec_order;
		@(posedge sys_clk_i) disable iff (rst_i)
		(vf_idle & vec_req_i) |=> vec_rd_o ##1 vec_rd_o &
			(vec_addr_o == $past(vec_addr_o) + 16'h0001) ##2 vec_done_o;
	endproperty
	a_vec_order: assert property (p_vec_order) else $error("vector fetch order");

	property p_deep_pwr;
		@(posedge sys_clk_i) disable iff (rst_i)
		(mode_o == MODE_DEEP) |-> pwr_o.core_off & pwr_o.ram_standby &
			pwr_o.io_hold & ~pwr_o.conv_on;
	endproperty
	a_deep_pwr: assert property (p_deep_pwr) else $error("deep stop power state");

	property p_dbg_periph;
		@(posedge sys_clk_i) disable iff (rst_i)
		(n_stop & dbg_en) |=> ~pwr_o.periph_clk_en & pwr_o.dbg_clk_en;
	endproperty
	a_dbg_periph: assert property (p_dbg_periph) else $error("peripheral clock with debug");

	property p_conv_off;
		@(posedge sys_clk_i) disable iff (rst_i)
		(n_stop & ~(ctrl_ff[CB_CONV_ACLK] & vm_en)) |=> ~pwr_o.conv_on;
	endproperty
	a_conv_off: assert property (p_conv_off) else $error("converter left on in stop");

	property p_vm_reg;
		@(posedge sys_clk_i) disable iff (rst_i)
		(n_stop & vm_stop) |=> pwr_o.reg_full;
	endproperty
	a_vm_reg: assert property (p_vm_reg) else $error("regulator dropped with monitor");

	property p_one_rsp;
		@(posedge sys_clk_i) disable iff (rst_i)
		cmd_v |=> $onehot(dbg_rsp_o);
	endproperty
	a_one_rsp: assert property (p_one_rsp) else $error("debug answer not unique");

	property p_region_hp;
		@(posedge sys_clk_i) disable iff (rst_i)
		((cpu_addr_i >= HP_LO) & (cpu_addr_i <= HP_HI)) |=>
			region_o.hp & ~region_o.dp & ~region_o.nv & ~region_o.uvec;
	endproperty
	a_region_hp: assert property (p_region_hp) else $error("high page decode");
endmodule : smp_ctrl

// ---- testbench/smp_vec_mem.sv ----
`timescale 1ns/100ps
module smp_vec_mem (
	input  wire logic        sys_clk_i,
	input  wire logic        vec_rd_i,
	input  wire logic [15:0] vec_addr_i,
	output logic      [7:0]  vec_data_o
);
	initial vec_data_o = 8'h3c;
	// Byte depends on address so a swapped fetch shows
	always @(posedge sys_clk_i) begin
		if (vec_rd_i) begin
			vec_data_o <= vec_addr_i[7:0] ^ 8'ha5;
		end else begin
			// Idle bus toggles instead of holding
			vec_data_o <= ~vec_data_o;
		end
	end
endmodule : smp_vec_mem

// ---- testbench/stop_mode_power_control_test.sv ----
`timescale 1ns/100ps
module stop_mode_power_control_test;
	import smp_pkg::*;
	localparam logic [7:0] DBG = 8'h01, VME = 8'h02, VMS = 8'h04, DSL = 8'h08;
	localparam logic [7:0] STE = 8'h10, VMR = 8'h20, CAC = 8'h40;
	logic            sys_clk_i = 1'b0, rst_i = 1'b1;
	logic [AW-1:0]   reg_addr_i = '0;
	logic [DW-1:0]   reg_wdata_i = '0, reg_rdata_o;
	logic            reg_wr_i = 1'b0, reg_rd_i = 1'b0, stop_exec_i = 1'b0, wake_i = 1'b0;
	smp_dbg_req_t    dbg_req_i = '0;
	smp_dbg_rsp_t    dbg_rsp_o;
	logic            lv_trip_i = 1'b0, lv_irq_o, lv_rst_o, ilop_rst_o;
	smp_pwr_t        pwr_o;
	smp_mode_t       mode_o;
	logic [15:0]     cpu_addr_i = '0, vec_addr_o, vec_o;
	smp_region_t     region_o;
	logic            vec_req_i = 1'b0, vec_rd_o, vec_done_o;
	smp_vec_t        vec_sel_i = VEC_RESET;
	logic [7:0]      vec_data_i;
	int              err_count = 0, check_count = 0, n;
	logic [15:0]     da [13] = '{16'h0000, 16'h005f, 16'h0060, 16'h17ff, 16'h1800, 16'h184f,
		16'h1850, 16'hffaf, 16'hffb0, 16'hffbf, 16'hffc0, 16'hffcf, 16'hffd0};
	logic [3:0]      dr [13] = '{4'h8, 4'h8, 4'h0, 4'h0, 4'h4, 4'h4, 4'h0, 4'h0, 4'h2, 4'h2,
		4'h1, 4'h1, 4'h0};
	logic [15:0]     va [12] = '{16'hfffe, 16'hfffc, 16'hfffa, 16'hfff8, 16'hfff4, 16'hfff2,
		16'hfff0, 16'hffee, 16'hffea, 16'hffda, 16'hffd8, 16'hffd0};

	always #4 sys_clk_i = ~sys_clk_i;

	smp_ctrl uut (.sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
		.reg_rdata_o, .stop_exec_i, .wake_i, .dbg_req_i, .dbg_rsp_o, .lv_trip_i, .lv_irq_o,
		.lv_rst_o, .ilop_rst_o, .pwr_o, .mode_o, .cpu_addr_i, .region_o, .vec_req_i,
		.vec_sel_i, .vec_rd_o, .vec_addr_o, .vec_data_i, .vec_o, .vec_done_o);
	smp_vec_mem mem (.sys_clk_i, .vec_rd_i(vec_rd_o), .vec_addr_i(vec_addr_o),
		.vec_data_o(vec_data_i));

	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	task automatic wr(input logic [AW-1:0] a, input logic [7:0] v);
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= v;
		@(posedge sys_clk_i);
		reg_wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [AW-1:0] a, input logic [7:0] exp);
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge sys_clk_i);
		reg_rd_i <= 1'b0;
		#1 chk("rdata", 16'(reg_rdata_o), 16'(exp));
	endtask : rd
	task automatic dbg(input smp_cmd_t c, input logic [2:0] exp);
		@(posedge sys_clk_i);
		dbg_req_i <= '{1'b1, c};
		@(posedge sys_clk_i);
		dbg_req_i.valid <= 1'b0;
		#1 chk(c.name(), 16'(dbg_rsp_o), 16'(exp));
	endtask : dbg
	task automatic pulse(input bit wk);
		@(posedge sys_clk_i);
		if (wk) wake_i <= 1'b1;
		else stop_exec_i <= 1'b1;
		@(posedge sys_clk_i);
		wake_i <= 1'b0;
		stop_exec_i <= 1'b0;
		#1;
	endtask : pulse
	task automatic md(input smp_mode_t m);
		chk("mode", 16'(mode_o), 16'(m));
	endtask : md
	task automatic pw(input logic [6:0] m, input logic [6:0] e);
		chk("pwr", 16'(pwr_o & m), 16'(e));
	endtask : pw
	task automatic lv(input int ei, input int er);
		int ni, nr;
		ni = 0;
		nr = 0;
		@(posedge sys_clk_i);
		lv_trip_i <= 1'b1;
		repeat (8) begin
			@(posedge sys_clk_i);
			#1;
			if (lv_irq_o === 1'b1) ni++;
			if (lv_rst_o === 1'b1) nr++;
		end
		@(posedge sys_clk_i);
		lv_trip_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		chk("lv_irq", 16'(ni), 16'(ei));
		chk("lv_rst", 16'(nr), 16'(er));
	endtask : lv

	initial begin
		repeat (19) @(posedge sys_clk_i);
		#1 md(MODE_RUN);
		pw(7'h7f, 7'h70);
		@(posedge sys_clk_i);
		rst_i <= 1'b0;
		rd(OFS_CTRL, CTRL_RST);
		dbg(CMD_HALT, 3'b001);
		dbg(CMD_GO, 3'b001);
		dbg(CMD_MEM_STAT, 3'b100);
		pulse(1'b0);
		chk("ilop", 16'(ilop_rst_o), 16'h1);
		md(MODE_RUN);
		$display("test run and stop-disabled done");
		wr(OFS_CTRL, STE | DSL);
		pulse(1'b0);
		md(MODE_DEEP);
		pw(7'h7f, 7'h07);
		dbg(CMD_HALT, 3'b001);
		pulse(1'b1);
		md(MODE_RUN);
		pw(7'h05, 7'h01);
		rd(OFS_STAT, 8'h14);
		wr(OFS_STAT, 8'hff);
		rd(OFS_STAT, 8'h14);
		rd(4'h7, 8'h00);
		wr(OFS_ACK, 8'h01);
		rd(OFS_STAT, 8'h00);
		pw(7'h01, 7'h00);
		$display("test deep stop done");
		wr(OFS_CTRL, STE);
		pulse(1'b0);
		md(MODE_LIGHT);
		pw(7'h74, 7'h00);
		dbg(CMD_HALT, 3'b001);
		pulse(1'b1);
		wr(OFS_CTRL, STE | DSL | DBG);
		pulse(1'b0);
		md(MODE_LIGHT);
		pw(7'h76, 7'h32);
		dbg(CMD_MEM, 3'b001);
		dbg(CMD_MEM_STAT, 3'b010);
		dbg(CMD_HALT, 3'b100);
		md(MODE_DEBUG);
		pw(7'h40, 7'h40);
		for (int c = 0; c < 5; c++) dbg(smp_cmd_t'(c), 3'b100);
		dbg(CMD_GO, 3'b100);
		md(MODE_RUN);
		$display("test debug in stop done");
		wr(OFS_CTRL, STE | DSL | VME | VMS | CAC);
		pulse(1'b0);
		md(MODE_LIGHT);
		pw(7'h5c, 7'h18);
		pulse(1'b1);
		wr(OFS_CTRL, STE | VME | VMS);
		pulse(1'b0);
		pw(7'h08, 7'h00);
		pulse(1'b1);
		wr(OFS_CTRL, STE | DSL | VME);
		pulse(1'b0);
		md(MODE_DEEP);
		pulse(1'b1);
		wr(OFS_ACK, 8'h01);
		wr(OFS_CTRL, VME);
		lv(1, 0);
		wr(OFS_CTRL, VME | VMR);
		lv(0, 1);
		$display("test voltage monitor done");
		for (int i = 0; i < 13; i++) begin
			@(posedge sys_clk_i);
			cpu_addr_i <= da[i];
			@(posedge sys_clk_i);
			#1 chk("region", 16'(region_o), 16'(dr[i]));
		end
		$display("test decode done");
		for (int i = 0; i < VEC_N; i++) begin
			@(posedge sys_clk_i);
			vec_req_i <= 1'b1;
			vec_sel_i <= smp_vec_t'(i);
			@(posedge sys_clk_i);
			vec_req_i <= 1'b0;
			n = 0;
			#1;
			while (vec_done_o !== 1'b1 && n < 8) begin
				@(posedge sys_clk_i);
				#1 n++;
			end
			if (n == 8) begin
				err_count++;
				wrap_up();
			end
			chk("vec_wait", 16'(n), 16'h3);
			chk("vec", vec_o, {va[i][7:0] ^ 8'ha5, (va[i][7:0] + 8'h1) ^ 8'ha5});
		end
		$display("test vectors done");
		wrap_up();
	end
endmodule : stop_mode_power_control_test
